// ### design/umd_dma_defs.vh
// Constants of the four-channel micro DMA engine.
// Assumes inclusion by umd_dma.v only.
`ifndef UMD_DMA_DEFS_VH
`define UMD_DMA_DEFS_VH

// ------------------------------------------------
// Register offsets (word index within a channel) and byte addresses
// ------------------------------------------------
`define UMD_OFS_SRC     2'h0
`define UMD_OFS_DST     2'h1
`define UMD_OFS_CNT     2'h2
`define UMD_OFS_VEC     2'h3
`define UMD_ADR_BURST   8'h80
`define UMD_ADR_STAT    8'h84
`define UMD_ADR_SOFT    8'h89

// ------------------------------------------------
// Field positions and codes
// ------------------------------------------------
`define UMD_VEC_MSB     7
`define UMD_MODE_LSB    8
`define UMD_MODE_MSB    12
`define UMD_VEC_FIRST   8'h0A
`define UMD_VEC_LAST    8'h33
`define UMD_SZ_BYTE     2'h0
`define UMD_SZ_WORD     2'h1
`define UMD_SZ_QUAD     2'h2
`define UMD_OP_DINC     3'h0
`define UMD_OP_DDEC     3'h1
`define UMD_OP_SINC     3'h2
`define UMD_OP_SDEC     3'h3
`define UMD_OP_FIX      3'h4
`define UMD_OP_CNT      3'h5

// ------------------------------------------------
// Levels, reset values and state counts
// ------------------------------------------------
`define UMD_DMA_LEVEL   3'h6
`define UMD_MASK_ALL    3'h7
`define UMD_RST_SOFT    4'h0
`define UMD_N_FETCH     3'h3
`define UMD_N_ACC       3'h2
`define UMD_N_EXTRA     3'h2
`define UMD_N_CNTMODE   3'h5

`endif

// ### design/umd_dma.v
// Four-channel micro DMA engine, interrupt or software started.
// Assumes one clock, synchronous inputs, a memory port that
// returns read data in the last state of a read phase.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "umd_dma_defs.vh"

module umd_dma #(
    parameter NSRC = 42
) (
    input  wire        sys_clk,        // System clock
    input  wire        rst,            // Async reset, high
    input  wire [7:0]  reg_addr,       // Register byte address
    input  wire [31:0] reg_wdata,      // Register write data
    input  wire        reg_wr,         // Write strobe
    input  wire        reg_rd,         // Read strobe
    output reg  [31:0] reg_rdata_ff,   // Read data, next cycle
    input  wire [NSRC-1:0] int_flag,   // Source request flags
    output reg  [NSRC-1:0] flag_clr_ff,// Flag clear pulses
    output reg  [NSRC-1:0] ord_req_ff, // Ordinary requests
    input  wire [2:0]  cpu_mask_level, // CPU mask level
    input  wire        cpu_halt,       // CPU in halted standby
    output reg         dma_req_ff,     // DMA request to CPU
    output reg  [2:0]  dma_lvl_ff,     // Level of that request
    output reg  [3:0]  transfer_end_irq, // End pulses per channel
    output reg  [23:0] mem_addr_ff,    // Memory address
    output reg         mem_rd_ff,      // Memory read state
    output reg         mem_wr_ff,      // Memory write state
    output reg  [1:0]  mem_size_ff,    // Item size code
    output reg  [31:0] mem_wdata_ff,   // Memory write data
    input  wire [31:0] mem_rdata,      // Memory read data
    input  wire        src_bus8,       // Source area is 8 bit
    input  wire        dst_bus8        // Dest area is 8 bit
);

// ------------------------------------------------
// States
// ------------------------------------------------
localparam ST_IDLE  = 3'h0;
localparam ST_FETCH = 3'h1;
localparam ST_READ  = 3'h2;
localparam ST_DUMMY = 3'h3;
localparam ST_WRITE = 3'h4;
localparam ST_CNTM  = 3'h5;
localparam ST_END   = 3'h6;

// ------------------------------------------------
// Functions
// ------------------------------------------------
// Pointer step for a size code
function [31:0] step_of;
    input [1:0] sz;
    begin
        case (sz)
            `UMD_SZ_WORD: step_of = 32'h0000_0002;
            `UMD_SZ_QUAD: step_of = 32'h0000_0004;
            default:      step_of = 32'h0000_0001;
        endcase
    end
endfunction

// Access length: 2, plus 2 for 8-bit, odd non-byte or quad
function [2:0] acc_len;
    input [1:0] sz;
    input       bus8;
    input       odd;
    begin
        if (bus8 || (odd && sz != `UMD_SZ_BYTE) ||
            sz == `UMD_SZ_QUAD) begin
            acc_len = `UMD_N_ACC + `UMD_N_EXTRA;
        end else begin
            acc_len = `UMD_N_ACC;
        end
    end
endfunction

// ------------------------------------------------
// Registers
// ------------------------------------------------
reg [31:0] src_ff [0:3];
reg [31:0] dst_ff [0:3];
reg [15:0] cnt_ff [0:3];
reg [7:0]  vec_ff [0:3];
reg [4:0]  mode_ff [0:3];
reg [3:0]  burst_ff;
reg [3:0]  soft_ff;
reg [2:0]  st_ff;
reg [2:0]  ph_ff;
reg [1:0]  ch_ff;
reg        by_soft_ff;
reg [31:0] data_ff;

reg [3:0]      int_pend;
reg [NSRC-1:0] bound;
reg [5:0]      pend_src [0:3];
reg [3:0]      pend;
reg [1:0]      pick;
reg            grant;
reg [15:0]     nxt_cnt;
integer        i;
integer        k;
// Own loop index per process, one driver each
integer        m;
integer        n;

wire [1:0] sz_w   = mode_ff[ch_ff][1:0];
wire [2:0] op_w   = mode_ff[ch_ff][4:2];
wire [31:0] step_w = step_of(sz_w);
wire       wr_ch  = reg_wr && reg_addr[7:6] == 2'h0;
wire [1:0] wr_idx = reg_addr[5:4];
wire       busy_w = st_ff != ST_IDLE;

// ------------------------------------------------
// Request decode and arbitration
// ------------------------------------------------
// Map each vector to a source and find pending channels
always @* begin
    bound = {NSRC{1'b0}};
    for (i = 0; i < 4; i = i + 1) begin
        int_pend[i] = 1'b0;
        pend_src[i] = 6'h00;
        for (k = 0; k < NSRC; k = k + 1) begin
            // Vectors 0AH..33H select the 42 sources
            if (vec_ff[i] == `UMD_VEC_FIRST + k[7:0]) begin
                bound[k]    = 1'b1;
                pend_src[i] = k[5:0];
                int_pend[i] = int_flag[k];
            end
        end
    end
    pend = int_pend | soft_ff;
end

// Lowest channel wins, no request when masked or halted
always @* begin
    pick = 2'h0;
    for (m = 3; m >= 0; m = m - 1) begin
        if (pend[m]) begin
            pick = m[1:0];
        end
    end
    grant = (|pend) && cpu_mask_level != `UMD_MASK_ALL
            && !cpu_halt;
end

// Decremented count
always @* begin
    nxt_cnt = cnt_ff[ch_ff] - 16'h0001;
end

// ------------------------------------------------
// Service sequencer and register file
// ------------------------------------------------
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        for (n = 0; n < 4; n = n + 1) begin
            src_ff[n]  <= 32'h0000_0000;
            dst_ff[n]  <= 32'h0000_0000;
            cnt_ff[n]  <= 16'h0000;
            vec_ff[n]  <= 8'h00;
            mode_ff[n] <= 5'h00;
        end
        burst_ff         <= 4'h0;
        soft_ff          <= `UMD_RST_SOFT;
        st_ff            <= ST_IDLE;
        ph_ff            <= 3'h0;
        ch_ff            <= 2'h0;
        by_soft_ff       <= 1'b0;
        data_ff          <= 32'h0000_0000;
        flag_clr_ff      <= {NSRC{1'b0}};
        ord_req_ff       <= {NSRC{1'b0}};
        dma_req_ff       <= 1'b0;
        dma_lvl_ff       <= 3'h0;
        transfer_end_irq <= 4'h0;
        mem_addr_ff      <= 24'h00_0000;
        mem_rd_ff        <= 1'b0;
        mem_wr_ff        <= 1'b0;
        mem_size_ff      <= 2'h0;
        mem_wdata_ff     <= 32'h0000_0000;
        reg_rdata_ff     <= 32'h0000_0000;
    end else begin
        flag_clr_ff      <= {NSRC{1'b0}};
        transfer_end_irq <= 4'h0;
        mem_rd_ff        <= 1'b0;
        mem_wr_ff        <= 1'b0;
        // Unbound sources go to the ordinary path
        ord_req_ff <= int_flag & ~bound;
        // Request at fixed level regardless of source level
        dma_req_ff <= grant && !busy_w;
        dma_lvl_ff <= (grant && !busy_w) ? `UMD_DMA_LEVEL : 3'h0;

        // Software register writes
        if (wr_ch) begin
            case (reg_addr[3:2])
                `UMD_OFS_SRC: src_ff[wr_idx] <= reg_wdata;
                `UMD_OFS_DST: dst_ff[wr_idx] <= reg_wdata;
                `UMD_OFS_CNT: cnt_ff[wr_idx] <= reg_wdata[15:0];
                default: begin
                    vec_ff[wr_idx]  <= reg_wdata[`UMD_VEC_MSB:0];
                    mode_ff[wr_idx] <=
                        reg_wdata[`UMD_MODE_MSB:`UMD_MODE_LSB];
                end
            endcase
        end
        if (reg_wr && reg_addr == `UMD_ADR_BURST) begin
            burst_ff <= reg_wdata[3:0];
        end

        case (st_ff)
            ST_IDLE: begin
                // Request rises on the edge the service starts
                if (grant && !dma_req_ff) begin
                    ch_ff      <= pick;
                    by_soft_ff <= !int_pend[pick];
                    if (int_pend[pick]) begin
                        // Clear the flag of the bound source
                        flag_clr_ff[pend_src[pick]] <= 1'b1;
                    end
                    st_ff <= ST_FETCH;
                    ph_ff <= `UMD_N_FETCH;
                end
            end
            ST_FETCH: begin
                // Three fetch states, then read or count mode
                if (ph_ff == 3'h1) begin
                    if (op_w == `UMD_OP_CNT) begin
                        st_ff <= ST_CNTM;
                        ph_ff <= `UMD_N_CNTMODE - `UMD_N_FETCH;
                    end else begin
                        st_ff <= ST_READ;
                        ph_ff <= acc_len(sz_w, src_bus8,
                                         src_ff[ch_ff][0]);
                    end
                end else begin
                    ph_ff <= ph_ff - 3'h1;
                end
            end
            ST_READ: begin
                // Item taken in the last read state
                mem_rd_ff   <= 1'b1;
                mem_size_ff <= sz_w;
                mem_addr_ff <= src_ff[ch_ff][23:0];
                if (ph_ff == 3'h1) begin
                    data_ff <= mem_rdata;
                    st_ff   <= ST_DUMMY;
                end else begin
                    ph_ff <= ph_ff - 3'h1;
                end
            end
            ST_DUMMY: begin
                // Address held from the last read state
                st_ff <= ST_WRITE;
                ph_ff <= acc_len(sz_w, dst_bus8, dst_ff[ch_ff][0]);
            end
            ST_WRITE: begin
                // Drive the item held since the read
                mem_wr_ff    <= 1'b1;
                mem_addr_ff  <= dst_ff[ch_ff][23:0];
                mem_wdata_ff <= data_ff;
                if (ph_ff == 3'h1) begin
                    st_ff <= ST_END;
                end else begin
                    ph_ff <= ph_ff - 3'h1;
                end
            end
            ST_CNTM: begin
                // Counter mode: no memory access
                if (ph_ff == 3'h1) begin
                    st_ff <= ST_END;
                end else begin
                    ph_ff <= ph_ff - 3'h1;
                end
            end
            ST_END: begin
                // Pointer update by mode and size
                case (op_w)
                    `UMD_OP_DINC:
                        dst_ff[ch_ff] <= dst_ff[ch_ff] + step_w;
                    `UMD_OP_DDEC:
                        dst_ff[ch_ff] <= dst_ff[ch_ff] - step_w;
                    `UMD_OP_SINC:
                        src_ff[ch_ff] <= src_ff[ch_ff] + step_w;
                    `UMD_OP_SDEC:
                        src_ff[ch_ff] <= src_ff[ch_ff] - step_w;
                    `UMD_OP_CNT:
                        src_ff[ch_ff] <= src_ff[ch_ff] + 32'h1;
                    default: ;
                endcase
                // Count down; 0000H wraps, giving 65536 items
                cnt_ff[ch_ff] <= nxt_cnt;
                if (by_soft_ff) begin
                    soft_ff[ch_ff] <= 1'b0;
                end
                if (nxt_cnt == 16'h0000) begin
                    transfer_end_irq[ch_ff] <= 1'b1;
                    vec_ff[ch_ff] <= 8'h00;
                    st_ff <= ST_IDLE;
                end else if (burst_ff[ch_ff] && !cpu_halt &&
                             cpu_mask_level != `UMD_MASK_ALL) begin
                    st_ff <= ST_FETCH;
                    ph_ff <= `UMD_N_FETCH;
                end else begin
                    st_ff <= ST_IDLE;
                end
            end
            default: st_ff <= ST_IDLE;
        endcase

        // Soft start: ones set, zeros do nothing; set beats clear
        if (reg_wr && reg_addr == `UMD_ADR_SOFT) begin
            for (n = 0; n < 4; n = n + 1) begin
                // Dropped on a channel busy with an interrupt start
                if (reg_wdata[n] && !(busy_w && ch_ff == n[1:0] &&
                                      !by_soft_ff)) begin
                    soft_ff[n] <= 1'b1;
                end
            end
        end

        // Read data one cycle after the strobe
        if (reg_rd) begin
            if (reg_addr[7:6] == 2'h0) begin
                case (reg_addr[3:2])
                    `UMD_OFS_SRC: reg_rdata_ff <= src_ff[reg_addr[5:4]];
                    `UMD_OFS_DST: reg_rdata_ff <= dst_ff[reg_addr[5:4]];
                    `UMD_OFS_CNT:
                        reg_rdata_ff <= {16'h0000, cnt_ff[reg_addr[5:4]]};
                    default: reg_rdata_ff <= {19'h00000,
                                mode_ff[reg_addr[5:4]],
                                vec_ff[reg_addr[5:4]]};
                endcase
            end else if (reg_addr == `UMD_ADR_BURST) begin
                reg_rdata_ff <= {28'h0000000, burst_ff};
            end else if (reg_addr == `UMD_ADR_STAT) begin
                reg_rdata_ff <= {24'h000000, busy_w, st_ff,
                                 by_soft_ff, 1'b0, ch_ff};
            end else if (reg_addr == `UMD_ADR_SOFT) begin
                reg_rdata_ff <= {28'h0000000, soft_ff};
            end else begin
                reg_rdata_ff <= 32'h0000_0000;
            end
        end else begin
            reg_rdata_ff <= 32'h0000_0000;
        end
    end
end

endmodule

// ### dv/umd_dma_asserts.sv
// Port assertions for the micro DMA engine.
// Assumes one clock and an async reset, active high.
`timescale 1ns/1ps
module umd_dma_chk #(
    parameter NSRC = 42
) (
    input wire            sys_clk,          // Clock
    input wire            rst,              // Reset
    input wire [2:0]      cpu_mask_level,   // CPU mask
    input wire            cpu_halt,         // CPU halted
    input wire            dma_req_ff,       // DMA request
    input wire [2:0]      dma_lvl_ff,       // Its level
    input wire [3:0]      transfer_end_irq, // End pulses
    input wire [NSRC-1:0] flag_clr_ff,      // Flag clears
    input wire [23:0]     mem_addr_ff,      // Address
    input wire            mem_rd_ff,        // Read state
    input wire            mem_wr_ff,        // Write state
    input wire [1:0]      mem_size_ff,      // Size code
    input wire            src_bus8          // 8-bit source
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // ---------------------------------------------
    // Steps of a word item
    // ---------------------------------------------
    sequence s_word_go;
        $rose(mem_rd_ff) && mem_size_ff == 2'h1 && !src_bus8
            && !mem_addr_ff[0];
    endsequence
    sequence s_rd2;
        mem_rd_ff [*2];
    endsequence
    sequence s_dummy;
        !mem_rd_ff && !mem_wr_ff && $stable(mem_addr_ff);
    endsequence

    // ---------------------------------------------
    // Request, level, pulses and memory access order
    // ---------------------------------------------
    a_req_unmasked: assert property ($rose(dma_req_ff) |->
        $past(cpu_mask_level) != 3'h7) else $error("request under mask");
    a_req_not_halted: assert property ($rose(dma_req_ff) |->
        !$past(cpu_halt)) else $error("request while halted");
    a_req_level: assert property (
        dma_lvl_ff == (dma_req_ff ? 3'h6 : 3'h0)) else $error("bad level");
    a_end_single: assert property (transfer_end_irq != 4'h0 |->
        $onehot(transfer_end_irq) ##1 transfer_end_irq == 4'h0)
        else $error("end pulse malformed");
    a_clr_on_accept: assert property (flag_clr_ff != 0 |->
        $onehot(flag_clr_ff) && dma_req_ff)
        else $error("flag clear without accept");
    a_word_steps: assert property (s_word_go |->
        s_rd2 ##1 s_dummy ##1 mem_wr_ff) else $error("word item order");
    a_slow_read: assert property ($rose(mem_rd_ff) &&
        (src_bus8 || mem_size_ff == 2'h2) |-> mem_rd_ff [*4] ##1 !mem_rd_ff)
        else $error("slow read length");
    a_rd_wr_excl: assert property (
        !(mem_rd_ff && mem_wr_ff)) else $error("read and write together");
    a_rd_then_wr: assert property ($rose(mem_rd_ff) |->
        ##[3:5] $rose(mem_wr_ff)) else $error("read not followed by write");
endmodule

// ### dv/umd_far_model.sv
// Far side: interrupt request flags and memory.
// Assumes the engine's clock and reset.
`timescale 1ns/1ps
module umd_far_model (
    input  wire        sys_clk,     // Clock
    input  wire        rst,         // Reset
    input  wire [41:0] fire,        // Source events
    input  wire [41:0] ack,         // CPU vector reads
    input  wire [41:0] flag_clr_ff, // Engine clears
    output reg  [41:0] int_flag,    // Request flags
    input  wire [23:0] mem_addr_ff, // Address
    input  wire        mem_rd_ff,   // Read state
    output wire [31:0] mem_rdata    // Read data
);
    wire [31:0] word = {8'hC3, mem_addr_ff};

    // Flags latch events until cleared
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            int_flag <= 42'h0;
        end else begin
            int_flag <= (int_flag | fire) & ~flag_clr_ff & ~ack;
        end
    end

    // Bus shows inverted data outside reads
    assign mem_rdata = mem_rd_ff ? word : ~word;
endmodule

// ### dv/testbench.sv
// Self-checking bench for the micro DMA engine.
// Assumes the engine, its checker and the far side model.
`timescale 1ns/1ps
module testbench;
    reg         sys_clk = 1'b0;
    reg         rst = 1'b1;
    reg  [7:0]  reg_addr = 8'h00;
    reg  [31:0] reg_wdata = 32'h0;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg  [2:0]  cpu_mask_level = 3'h0;
    reg         cpu_halt = 1'b0;
    reg         src_bus8 = 1'b0;
    reg         dst_bus8 = 1'b0;
    reg  [41:0] fire = 42'h0;
    reg  [41:0] ack = 42'h0;
    wire [31:0] reg_rdata_ff, mem_rdata, mem_wdata_ff;
    wire [41:0] int_flag, flag_clr_ff, ord_req_ff;
    wire        dma_req_ff, mem_rd_ff, mem_wr_ff;
    wire [2:0]  dma_lvl_ff;
    wire [3:0]  transfer_end_irq;
    wire [23:0] mem_addr_ff;
    wire [1:0]  mem_size_ff;
    reg  [31:0] v, last_wd;
    reg  [23:0] last_wa;
    reg  [41:0] first_clr = 42'h0;
    reg  [3:0]  ends = 4'h0;
    reg  [7:0]  nwr = 8'h00;
    reg         req_seen = 1'b0;
    reg         wr_q = 1'b0;
    integer     num_errors = 0, compares = 0, i, j, k;

    umd_dma #(.NSRC(42)) u_umd_dma (.sys_clk(sys_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .int_flag(int_flag),
        .flag_clr_ff(flag_clr_ff), .ord_req_ff(ord_req_ff),
        .cpu_mask_level(cpu_mask_level), .cpu_halt(cpu_halt),
        .dma_req_ff(dma_req_ff), .dma_lvl_ff(dma_lvl_ff),
        .transfer_end_irq(transfer_end_irq), .mem_addr_ff(mem_addr_ff),
        .mem_rd_ff(mem_rd_ff), .mem_wr_ff(mem_wr_ff),
        .mem_size_ff(mem_size_ff), .mem_wdata_ff(mem_wdata_ff),
        .mem_rdata(mem_rdata), .src_bus8(src_bus8), .dst_bus8(dst_bus8));
    umd_far_model u_umd_far_model (.sys_clk(sys_clk), .rst(rst),
        .fire(fire), .ack(ack), .flag_clr_ff(flag_clr_ff),
        .int_flag(int_flag), .mem_addr_ff(mem_addr_ff),
        .mem_rd_ff(mem_rd_ff), .mem_rdata(mem_rdata));

    // ---------------------------------------------
    // Clock and monitors
    // ---------------------------------------------
    always #4 sys_clk = ~sys_clk;

    // Record writes, end pulses, first clear, requests
    always @(posedge sys_clk) begin
        wr_q <= mem_wr_ff;
        if (mem_wr_ff && !wr_q) begin
            last_wa <= mem_addr_ff;
            last_wd <= mem_wdata_ff;
            nwr <= nwr + 8'h01;
        end
        ends <= ends | transfer_end_irq;
        if (first_clr == 42'h0) first_clr <= flag_clr_ff;
        if (dma_req_ff) req_seen <= 1'b1;
    end

    // ---------------------------------------------
    // Tasks
    // ---------------------------------------------
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge sys_clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge sys_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge sys_clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge sys_clk);
            reg_rd <= 1'b0;
            #1 v = reg_rdata_ff;
        end
    endtask
    task chk(input [8*10-1:0] name, input [31:0] e, input [31:0] g);
        begin
            compares = compares + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("MISMATCH %0s exp %h got %h", name, e, g);
            end
        end
    endtask
    task cfg(input [1:0] ch, input [31:0] s, d, c, m);
        begin
            wr({2'h0, ch, 4'h0}, s);
            wr({2'h0, ch, 4'h4}, d);
            wr({2'h0, ch, 4'h8}, c);
            wr({2'h0, ch, 4'hC}, m);
        end
    endtask
    task mclr;
        begin
            #1 ends = 4'h0;
            nwr = 8'h00;
            first_clr = 42'h0;
            req_seen = 1'b0;
        end
    endtask
    task trig(input [41:0] b);
        begin
            @(posedge sys_clk);
            fire <= b;
            @(posedge sys_clk);
            fire <= 42'h0;
        end
    endtask
    // Wait for a request, then for 12 quiet cycles
    task svc;
        begin
            k = 0;
            while (!dma_req_ff && k < 100) begin
                @(posedge sys_clk);
                k = k + 1;
            end
            i = 0;
            while (i < 12 && k < 2000) begin
                @(posedge sys_clk);
                k = k + 1;
                i = (dma_req_ff || mem_rd_ff || mem_wr_ff) ? 0 : i + 1;
            end
            chk("svc_done", 32'h1, {31'h0, k < 2000});
        end
    endtask
    task close_out;
        begin
            $display("compares %0d errors %0d", compares, num_errors);
            if (num_errors == 0 && compares > 0) begin
                $display("TEST PASSED");
            end else begin
                $display("TEST FAILED");
            end
            $finish;
        end
    endtask

    // ---------------------------------------------
    // Tests
    // ---------------------------------------------
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'h89);
        chk("soft_rst", 32'h0, v);
        rd(8'hFC);
        chk("unmapped", 32'h0, v);
        cfg(2'h0, 32'hFF001000, 32'hAB002000, 32'h2, 32'h10A);
        mclr;
        trig(42'h1);
        svc;
        chk("wr_addr", 32'h2000, {8'h0, last_wa});
        chk("wr_data", 32'h1000, {16'h0, last_wd[15:0]});
        chk("flag_clr", 32'h1, first_clr[31:0]);
        chk("no_end", 32'h0, {28'h0, ends});
        rd(8'h08);
        chk("count", 32'h1, v);
        rd(8'h04);
        chk("dst_ptr", 32'h2002, {8'h0, v[23:0]});
        mclr;
        trig(42'h1);
        svc;
        chk("end_irq", 32'h1, {28'h0, ends});
        rd(8'h0C);
        chk("vector", 32'h0, {24'h0, v[7:0]});
        trig(42'h1);
        repeat (3) @(posedge sys_clk);
        chk("ord_req", 32'h1, {31'h0, ord_req_ff[0]});
        ack <= 42'h1;
        @(posedge sys_clk);
        ack <= 42'h0;
        cpu_mask_level <= 3'h7;
        cfg(2'h0, 32'h1000, 32'h2000, 32'h1, 32'h10A);
        mclr;
        trig(42'h1);
        repeat (20) @(posedge sys_clk);
        chk("mask_req", 32'h0, {31'h0, req_seen});
        cpu_mask_level <= 3'h0;
        cpu_halt <= 1'b1;
        repeat (20) @(posedge sys_clk);
        chk("halt_req", 32'h0, {31'h0, req_seen});
        cpu_halt <= 1'b0;
        svc;
        chk("pend_end", 32'h1, {28'h0, ends});
        cfg(2'h1, 32'h1000, 32'h3000, 32'h5, 32'h10B);
        cfg(2'h2, 32'h1000, 32'h4000, 32'h5, 32'h10C);
        mclr;
        trig(42'h6);
        svc;
        svc;
        chk("first_ch", 32'h2, first_clr[31:0]);
        chk("both_clr", 32'h0, {22'h0, int_flag[9:0]});
        src_bus8 <= 1'b1;
        dst_bus8 <= 1'b1;
        for (j = 0; j < 3; j = j + 1) begin
            cfg(2'h3, 32'h1000, 32'h6000, 32'h2, j << 8);
            wr(8'h89, 32'h8);
            svc;
            rd(8'h34);
            chk("size_step", 32'h6000 + (1 << j), {8'h0, v[23:0]});
            rd(8'h38);
            chk("soft_cnt", 32'h1, v);
            rd(8'h89);
            chk("soft_clr", 32'h0, v);
        end
        src_bus8 <= 1'b0;
        dst_bus8 <= 1'b0;
        wr(8'h80, 32'h1);
        cfg(2'h0, 32'h1000, 32'h2000, 32'h3, 32'h100);
        mclr;
        wr(8'h89, 32'h1);
        svc;
        chk("burst_wr", 32'h3, {24'h0, nwr});
        chk("burst_end", 32'h1, {28'h0, ends});
        cfg(2'h1, 32'h10, 32'h20, 32'h2, 32'h1400);
        cfg(2'h2, 32'h1000, 32'h2000, 32'h2, 32'h0D00);
        mclr;
        wr(8'h89, 32'h2);
        svc;
        wr(8'h89, 32'h4);
        svc;
        rd(8'h10);
        chk("cnt_mode", 32'h11, v);
        chk("cnt_nowr", 32'h1, {24'h0, nwr});
        rd(8'h20);
        chk("src_dec", 32'h0FFE, v);
        close_out;
    end

    // Cut a hang short
    initial begin
        #400000;
        num_errors = num_errors + 1;
        close_out;
    end
endmodule

bind umd_dma umd_dma_chk #(.NSRC(NSRC)) u_umd_dma_chk (
    .sys_clk(sys_clk), .rst(rst), .cpu_mask_level(cpu_mask_level),
    .cpu_halt(cpu_halt), .dma_req_ff(dma_req_ff), .dma_lvl_ff(dma_lvl_ff),
    .transfer_end_irq(transfer_end_irq), .flag_clr_ff(flag_clr_ff),
    .mem_addr_ff(mem_addr_ff), .mem_rd_ff(mem_rd_ff),
    .mem_wr_ff(mem_wr_ff), .mem_size_ff(mem_size_ff), .src_bus8(src_bus8));
